//--- bench/ptg_cfg_stats_sva.sv
/*
 Checker for the test generator configuration and statistics block.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module ptg_cfg_stats_sva (
	input wire logic ref_clk_i, // Core clock
	input wire logic resetn_i, // Reset, active low
	input wire logic [11:0] reg_addr_i, // Register index
	input wire logic reg_rd_i, // Read strobe
	input wire logic [15:0] reg_rdata_o, // Read data
	input wire logic chk_byte_i, // Checker byte strobe
	input wire logic chk_frame_i, // Checker frame strobe
	input wire logic gen_byte_o, // Generated byte
	input wire logic gen_frame_start_o, // Frame start
	input wire logic gen_busy_o, // Generator busy
	input wire logic byte_wrap_o, // Byte wrap pulse
	input wire logic frame_wrap_o // Frame wrap pulse
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!resetn_i);
	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	sequence s_rd(a);
		reg_rd_i && reg_addr_i == a;
	endsequence
	a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
		else $error("read data not zero outside read cycle");
	a_unmapped_zero: assert property (reg_rd_i && reg_addr_i[11:8] == 4'h7
		|=> reg_rdata_o == 16'h0000)
		else $error("unmapped read not zero");
	a_gap_reserved: assert property (s_rd(ptg_pkg::REG_FRAME_GAP)
		|=> reg_rdata_o[15:8] == 8'h00)
		else $error("gap reserved bits not zero");
	a_status_reserved: assert property (s_rd(ptg_pkg::REG_STATUS_FLAGS)
		|=> reg_rdata_o[15:13] == 3'h0 && reg_rdata_o[7:0] == 8'h00)
		else $error("status reserved bits not zero");
	// ------------------------------------------------------------
	// Generator pacing and wrap pulses
	// ------------------------------------------------------------
	a_start_is_byte: assert property (gen_frame_start_o |-> gen_byte_o)
		else $error("frame start without byte");
	a_start_after_gap: assert property (gen_frame_start_o |-> !$past(gen_byte_o))
		else $error("frame start without gap");
	a_busy_with_byte: assert property (gen_byte_o |-> gen_busy_o)
		else $error("byte while not busy");
	a_byte_wrap_cause: assert property (byte_wrap_o |-> $past(chk_byte_i, 2))
		else $error("byte wrap without byte strobe");
	a_frame_wrap_cause: assert property (frame_wrap_o |-> $past(chk_frame_i, 2))
		else $error("frame wrap without frame strobe");
	a_wrap_one_cycle: assert property (byte_wrap_o |=> !byte_wrap_o)
		else $error("byte wrap longer than one cycle");
endmodule : ptg_cfg_stats_sva

bind ptg_cfg_stats ptg_cfg_stats_sva sva_u (.ref_clk_i(ref_clk_i),
	.resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .chk_byte_i(chk_byte_i),
	.chk_frame_i(chk_frame_i), .gen_byte_o(gen_byte_o),
	.gen_frame_start_o(gen_frame_start_o), .gen_busy_o(gen_busy_o),
	.byte_wrap_o(byte_wrap_o), .frame_wrap_o(frame_wrap_o));

//--- bench/ptg_cfg_stats_tb.sv
/*
 Bench for the test generator configuration and statistics block.
 Assumes a two-frame run and the far-end model looping bytes back.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
	fails++; $display("wrong value at %0t: %h not %h", $time, got, exp); \
	end end
module ptg_cfg_stats_tb;
	logic ref_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [11:0] reg_addr_i = 12'h000;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic chk_lock_i = 1'b0;
	logic extra_byte = 1'b0;
	logic [15:0] reg_rdata_o;
	logic chk_byte_i, chk_frame_i, gen_byte_o, gen_frame_start_o;
	logic gen_busy_o, byte_wrap_o, frame_wrap_o, irq_o;
	int fails = 0;
	int comparisons = 0;
	int c, nb, ns, s0, s1;
	logic [27:0] rst_tab [9] = '{28'h61A05DC, 28'h61B007D, 28'h61C0000,
		28'h61D0000, 28'h61E0000, 28'h6200000, 28'h6310000, 28'h6320000,
		28'h7FF0000};
	always #2.5 ref_clk_i = ~ref_clk_i;
	ptg_cfg_stats #(.FRAME_COUNT(2)) dut_u (.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .chk_byte_i(chk_byte_i),
		.chk_frame_i(chk_frame_i), .chk_lock_i(chk_lock_i),
		.gen_byte_o(gen_byte_o), .gen_frame_start_o(gen_frame_start_o),
		.gen_busy_o(gen_busy_o), .byte_wrap_o(byte_wrap_o),
		.frame_wrap_o(frame_wrap_o), .irq_o(irq_o));
	ptg_far_end far_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
		.gen_byte_i(gen_byte_o), .gen_frame_start_i(gen_frame_start_o),
		.extra_byte_i(extra_byte), .chk_byte_o(chk_byte_i),
		.chk_frame_o(chk_frame_i));
	// ------------------------------------------------------------
	// Access and stimulus tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [15:0] e);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		`CHK(reg_rdata_o, e)
	endtask : rd
	task automatic bytes(input int n);
		@(posedge ref_clk_i);
		extra_byte <= 1'b1;
		repeat (n) @(posedge ref_clk_i);
		extra_byte <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		#1;
	endtask : bytes
	task automatic tick;
		@(posedge ref_clk_i);
		#1;
	endtask : tick
	task automatic final_report;
		$display("comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	task automatic timeout;
		fails++;
		$display("wrong value at %0t: wait ran out", $time);
		final_report();
	endtask : timeout
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		foreach (rst_tab[i]) rd(rst_tab[i][27:16], rst_tab[i][15:0]);
		wr(12'h61C, 16'hFFFF);
		rd(12'h61C, 16'h0000);
		wr(12'h61B, 16'hFFFF);
		rd(12'h61B, 16'h00FF);
		wr(12'h61A, 16'h0003);
		rd(12'h61A, 16'h0003);
		wr(12'h61B, 16'h0002);
		$display("test registers done");
		wr(12'h632, 16'h0001);
		wr(12'h630, 16'h0005);
		c = 0;
		nb = 0;
		ns = 0;
		s0 = 0;
		s1 = 0;
		while (!(ns == 2 && gen_busy_o === 1'b0)) begin
			tick();
			c++;
			nb += (gen_byte_o === 1'b1);
			if (gen_frame_start_o === 1'b1) begin
				if (ns == 0) s0 = c; else s1 = c;
				ns++;
			end
			if (c > 100) timeout();
		end
		`CHK(nb, 6)
		`CHK(s1 - s0, 5)
		repeat (3) @(posedge ref_clk_i);
		wr(12'h620, 16'h0001);
		rd(12'h61C, 16'h0006);
		rd(12'h61D, 16'h0002);
		rd(12'h61E, 16'h0000);
		rd(12'h620, 16'h1000);
		`CHK(irq_o, 1'b1)
		rd(12'h631, 16'h0001);
		wr(12'h633, 16'h0001);
		tick();
		`CHK(irq_o, 1'b0)
		$display("test generator done");
		bytes(4);
		rd(12'h61C, 16'h0006);
		wr(12'h620, 16'h0001);
		rd(12'h61C, 16'h000A);
		wr(12'h620, 16'h0002);
		wr(12'h620, 16'h0001);
		rd(12'h61C, 16'h0000);
		rd(12'h61D, 16'h0000);
		wr(12'h630, 16'h0000);
		bytes(3);
		wr(12'h620, 16'h0001);
		rd(12'h61C, 16'h0000);
		wr(12'h630, 16'h0001);
		$display("test freeze and clear done");
		bytes(65536);
		wr(12'h620, 16'h0001);
		rd(12'h61C, 16'hFFFF);
		rd(12'h620, 16'h1200);
		rd(12'h631, 16'h0000);
		wr(12'h630, 16'h0003);
		bytes(1);
		c = 0;
		while (byte_wrap_o !== 1'b1) begin
			tick();
			c++;
			if (c > 8) timeout();
		end
		`CHK(irq_o, 1'b0)
		wr(12'h620, 16'h0001);
		rd(12'h61C, 16'h0000);
		rd(12'h631, 16'h0002);
		wr(12'h632, 16'h0002);
		tick();
		`CHK(irq_o, 1'b1)
		wr(12'h633, 16'h0002);
		tick();
		`CHK(irq_o, 1'b0)
		wr(12'h620, 16'h0002);
		rd(12'h620, 16'h1000);
		$display("test saturation and wrap done");
		chk_lock_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		rd(12'h620, 16'h1100);
		rd(12'h631, 16'h0008);
		$display("test lock done");
		final_report();
	end
endmodule : ptg_cfg_stats_tb

//--- bench/ptg_far_end.sv
/*
 Far-side receive model: returns generated bytes as checker strobes one
 cycle later, plus byte strobes commanded by the bench.
*/
`timescale 1ns/1ps
module ptg_far_end (
	input wire logic ref_clk_i, // Core clock
	input wire logic resetn_i, // Reset, active low
	input wire logic gen_byte_i, // Generated byte
	input wire logic gen_frame_start_i, // Generated frame start
	input wire logic extra_byte_i, // Bench byte strobe
	output logic chk_byte_o, // Received byte
	output logic chk_frame_o // Received frame
);
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			chk_byte_o <= 1'b0;
			chk_frame_o <= 1'b0;
		end else begin
			chk_byte_o <= gen_byte_i | extra_byte_i;
			chk_frame_o <= gen_frame_start_i;
		end
	end
endmodule : ptg_far_end

//--- rtl/ptg_cfg_stats.sv
/*
 Configuration and statistics part of a built-in frame generator/checker.
 Holds frame length and gap settings, paces generated frames, keeps
 checker byte and frame totals with freeze and clear, status flags and
 an interrupt. Assumes checker strobes come from logic on ref_clk_i and
 the lock indication arrives asynchronously.
*/
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
// Notes on behaviour
// - 16-bit writable frame length, reset 5DCh, sizes all generated frames.
// - Gap between generated frames equals 8-bit gap setting, reset 7Dh.
// - Software reads a 16-bit total of bytes received by checker.
// - In single mode the byte total holds at FFFFh.
// - Writing status bit 0 or 1 freezes the readable totals.
// - Received frames count in 32 bits; low half readable alone.
// - High half of frame total sits two words after byte total.
// - In single mode the frame total holds at 0FFFFFFFh.
// - Mode one wraps with a pulse at maximum; mode zero stops.
// - Done flag bit 12 after FRAME_COUNT frames sent; busy bit 11 meanwhile.
// - Overflow flags at bits 10 and 9; checker lock at bit 8.
module ptg_cfg_stats #(
	parameter int FRAME_COUNT = 16
) (
	input wire logic ref_clk_i, // Core clock, 200 MHz
	input wire logic resetn_i, // Async reset, active low
	input wire logic [11:0] reg_addr_i, // Register index
	input wire logic [15:0] reg_wdata_i, // Write data
	input wire logic reg_wr_i, // Write strobe
	input wire logic reg_rd_i, // Read strobe
	output logic [15:0] reg_rdata_o, // Read data, cycle after strobe
	input wire logic chk_byte_i, // Checker received one byte
	input wire logic chk_frame_i, // Checker received one frame
	input wire logic chk_lock_i, // Checker locked, asynchronous
	output logic gen_byte_o, // Generator emits one frame byte
	output logic gen_frame_start_o, // First byte of a frame
	output logic gen_busy_o, // Generation in progress
	output logic byte_wrap_o, // Byte total wrapped pulse
	output logic frame_wrap_o, // Frame total wrapped pulse
	output logic irq_o // Interrupt, level
);
	localparam int IRQ_BITS_W = ptg_pkg::IRQ_BITS;

	logic [15:0] frame_length;
	logic [7:0] frame_gap;
	logic chk_enable;
	logic cnt_mode;
	logic send;
	logic [15:0] byte_count;
	logic [31:0] frame_count;
	logic byte_wrap;
	logic frame_wrap;
	logic [15:0] byte_snap;
	logic [31:0] frame_snap;
	logic frozen;
	logic byte_ovf;
	logic frame_ovf;
	logic done;
	logic lock_meta;
	logic lock_sync;
	logic lock_prev;
	logic [IRQ_BITS_W-1:0] irq_status;
	logic [IRQ_BITS_W-1:0] irq_enable;
	logic [IRQ_BITS_W-1:0] irq_event;
	logic [15:0] len_cnt;
	logic [15:0] frames_left;
	ptg_pkg::ptg_gen_state_t gen_state;
	logic wr_status;
	logic do_freeze;
	logic do_clear;
	logic last_frame_byte;
	logic [15:0] next_rdata;

	assign wr_status = reg_wr_i && (reg_addr_i == ptg_pkg::REG_STATUS_FLAGS);
	assign do_freeze = wr_status && (reg_wdata_i[ptg_pkg::BIT_FREEZE]
		|| reg_wdata_i[ptg_pkg::BIT_FREEZE_CLEAR]);
	assign do_clear = wr_status && reg_wdata_i[ptg_pkg::BIT_FREEZE_CLEAR];

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			frame_length <= ptg_pkg::FRAME_LENGTH_RST;
			frame_gap <= ptg_pkg::FRAME_GAP_RST;
		end else if (reg_wr_i) begin
			if (reg_addr_i == ptg_pkg::REG_FRAME_LENGTH) begin
				frame_length <= reg_wdata_i;
			end
			if (reg_addr_i == ptg_pkg::REG_FRAME_GAP) begin
				frame_gap <= reg_wdata_i[7:0];
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			chk_enable <= ptg_pkg::CHK_CTRL_RST[ptg_pkg::BIT_CHK_ENABLE];
			cnt_mode <= ptg_pkg::CHK_CTRL_RST[ptg_pkg::BIT_CNT_MODE];
		end else if (reg_wr_i && reg_addr_i == ptg_pkg::REG_CHK_CTRL) begin
			chk_enable <= reg_wdata_i[ptg_pkg::BIT_CHK_ENABLE];
			cnt_mode <= reg_wdata_i[ptg_pkg::BIT_CNT_MODE];
		end
	end

	// ----------------------------------------------------------------
	// Frame generator pacing
	// ----------------------------------------------------------------
	// Last count of a frame or gap; a zero setting still spends one cycle
	assign last_frame_byte = (len_cnt == 16'h0001) || (len_cnt == 16'h0000);

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			send <= 1'b0;
		end else if (gen_state == ptg_pkg::GEN_GAP && last_frame_byte
			&& frames_left == 16'h0000) begin
			send <= 1'b0;
		end else if (reg_wr_i && reg_addr_i == ptg_pkg::REG_CHK_CTRL) begin
			send <= reg_wdata_i[ptg_pkg::BIT_SEND];
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			gen_state <= ptg_pkg::GEN_IDLE;
			len_cnt <= '0;
			frames_left <= '0;
		end else begin
			unique case (gen_state)
				ptg_pkg::GEN_IDLE: begin
					if (send) begin
						gen_state <= ptg_pkg::GEN_FRAME;
						len_cnt <= frame_length;
						frames_left <= 16'(FRAME_COUNT - 1);
					end
				end
				ptg_pkg::GEN_FRAME: begin
					if (!send) begin
						gen_state <= ptg_pkg::GEN_IDLE;
					end else if (last_frame_byte) begin
						gen_state <= ptg_pkg::GEN_GAP;
						len_cnt <= {8'h00, frame_gap};
					end else begin
						len_cnt <= len_cnt - 16'h0001;
					end
				end
				ptg_pkg::GEN_GAP: begin
					if (!send) begin
						gen_state <= ptg_pkg::GEN_IDLE;
					end else if (!last_frame_byte) begin
						len_cnt <= len_cnt - 16'h0001;
					end else if (frames_left == 16'h0000) begin
						gen_state <= ptg_pkg::GEN_IDLE;
					end else begin
						gen_state <= ptg_pkg::GEN_FRAME;
						len_cnt <= frame_length;
						frames_left <= frames_left - 16'h0001;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			done <= 1'b0;
		end else if (gen_state == ptg_pkg::GEN_GAP && last_frame_byte
			&& frames_left == 16'h0000 && send) begin
			done <= 1'b1;
		end else if (gen_state == ptg_pkg::GEN_IDLE && send) begin
			done <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			gen_byte_o <= 1'b0;
			gen_frame_start_o <= 1'b0;
			gen_busy_o <= 1'b0;
		end else begin
			gen_byte_o <= (gen_state == ptg_pkg::GEN_FRAME) && send;
			gen_frame_start_o <= send && len_cnt == frame_length
				&& gen_state == ptg_pkg::GEN_FRAME;
			gen_busy_o <= (gen_state != ptg_pkg::GEN_IDLE);
		end
	end

	// ----------------------------------------------------------------
	// Checker totals
	// ----------------------------------------------------------------
	ptg_counter #(
		.WIDTH(16),
		.MAX(ptg_pkg::BYTE_TOTAL_MAX)
	) u_byte_total (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.inc_i(chk_byte_i && chk_enable),
		.clear_i(do_clear),
		.wrap_i(cnt_mode),
		.count_o(byte_count),
		.wrap_o(byte_wrap)
	);

	ptg_counter #(
		.WIDTH(32),
		.MAX(ptg_pkg::FRAME_TOTAL_MAX)
	) u_frame_total (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.inc_i(chk_frame_i && chk_enable),
		.clear_i(do_clear),
		.wrap_i(cnt_mode),
		.count_o(frame_count),
		.wrap_o(frame_wrap)
	);

	// Snapshot taken before the clear so the frozen view shows old totals
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			byte_snap <= '0;
			frame_snap <= '0;
			frozen <= 1'b0;
		end else if (do_freeze) begin
			byte_snap <= byte_count;
			frame_snap <= frame_count;
			frozen <= 1'b1;
		end
	end

	// Overflow flags: set wins over clear
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			byte_ovf <= 1'b0;
			frame_ovf <= 1'b0;
		end else begin
			if (byte_wrap || (chk_byte_i && chk_enable
				&& byte_count == ptg_pkg::BYTE_TOTAL_MAX)) begin
				byte_ovf <= 1'b1;
			end else if (do_clear) begin
				byte_ovf <= 1'b0;
			end
			if (frame_wrap || (chk_frame_i && chk_enable
				&& frame_count == ptg_pkg::FRAME_TOTAL_MAX)) begin
				frame_ovf <= 1'b1;
			end else if (do_clear) begin
				frame_ovf <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			byte_wrap_o <= 1'b0;
			frame_wrap_o <= 1'b0;
		end else begin
			byte_wrap_o <= byte_wrap;
			frame_wrap_o <= frame_wrap;
		end
	end

	// ----------------------------------------------------------------
	// Lock synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			lock_meta <= 1'b0;
			lock_sync <= 1'b0;
			lock_prev <= 1'b0;
		end else begin
			lock_meta <= chk_lock_i;
			lock_sync <= lock_meta;
			lock_prev <= lock_sync;
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	assign irq_event[ptg_pkg::IRQ_DONE] = (gen_state == ptg_pkg::GEN_GAP)
		&& last_frame_byte && frames_left == 16'h0000 && send;
	assign irq_event[ptg_pkg::IRQ_BYTE_WRAP] = byte_wrap;
	assign irq_event[ptg_pkg::IRQ_FRAME_WRAP] = frame_wrap;
	assign irq_event[ptg_pkg::IRQ_LOCK] = lock_sync && !lock_prev;

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_status <= '0;
		end else if (reg_wr_i && reg_addr_i == ptg_pkg::REG_IRQ_CLEAR) begin
			irq_status <= (irq_status & ~reg_wdata_i[IRQ_BITS_W-1:0])
				| irq_event;
		end else begin
			irq_status <= irq_status | irq_event;
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_enable <= '0;
		end else if (reg_wr_i && reg_addr_i == ptg_pkg::REG_IRQ_ENABLE) begin
			irq_enable <= reg_wdata_i[IRQ_BITS_W-1:0];
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_status & irq_enable);
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = '0;
		unique case (reg_addr_i)
			ptg_pkg::REG_FRAME_LENGTH: next_rdata = frame_length;
			ptg_pkg::REG_FRAME_GAP: next_rdata = {8'h00, frame_gap};
			ptg_pkg::REG_BYTE_TOTAL:
				next_rdata = frozen ? byte_snap : byte_count;
			ptg_pkg::REG_FRAME_LOW:
				next_rdata = frozen ? frame_snap[15:0]
					: frame_count[15:0];
			ptg_pkg::REG_FRAME_HIGH:
				next_rdata = frozen ? frame_snap[31:16]
					: frame_count[31:16];
			ptg_pkg::REG_STATUS_FLAGS: begin
				next_rdata[ptg_pkg::BIT_DONE] = done;
				next_rdata[ptg_pkg::BIT_BUSY] = gen_busy_o;
				next_rdata[ptg_pkg::BIT_FRAME_OVF] = frame_ovf;
				next_rdata[ptg_pkg::BIT_BYTE_OVF] = byte_ovf;
				next_rdata[ptg_pkg::BIT_LOCK] = lock_sync;
			end
			ptg_pkg::REG_CHK_CTRL: begin
				next_rdata[ptg_pkg::BIT_CHK_ENABLE] = chk_enable;
				next_rdata[ptg_pkg::BIT_CNT_MODE] = cnt_mode;
				next_rdata[ptg_pkg::BIT_SEND] = send;
			end
			ptg_pkg::REG_IRQ_STATUS: next_rdata[IRQ_BITS_W-1:0] = irq_status;
			ptg_pkg::REG_IRQ_ENABLE: next_rdata[IRQ_BITS_W-1:0] = irq_enable;
			default: next_rdata = '0;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i) begin
			reg_rdata_o <= next_rdata;
		end else begin
			reg_rdata_o <= '0;
		end
	end
endmodule : ptg_cfg_stats

//--- rtl/ptg_counter.sv
/*
 Saturating or wrapping event counter with synchronous clear.
 Assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module ptg_counter #(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] MAX = '1
) (
	input wire logic ref_clk_i, // Core clock
	input wire logic resetn_i, // Async reset, active low
	input wire logic inc_i, // Count one event
	input wire logic clear_i, // Synchronous clear
	input wire logic wrap_i, // 1 continuous, 0 single
	output logic [WIDTH-1:0] count_o, // Current count
	output logic wrap_o // One-cycle pulse on wrap at max
);
	logic at_max;
	assign at_max = (count_o == MAX);

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			count_o <= '0;
		end else if (clear_i) begin
			count_o <= '0;
		end else if (inc_i) begin
			if (at_max) begin
				if (wrap_i) begin
					count_o <= '0;
				end
			end else begin
				count_o <= count_o + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wrap_o <= 1'b0;
		end else begin
			wrap_o <= inc_i && at_max && wrap_i && !clear_i;
		end
	end
endmodule : ptg_counter

//--- rtl/ptg_pkg.sv
/*
 Package for the test generator configuration and checker statistics block.
 Holds register indices, field positions, reset values and counter limits.
 Assumes a 16-bit register port addressed by register index.
*/
package ptg_pkg;
	// --------------------------------------------------------------
	// Register indices
	// --------------------------------------------------------------
	localparam logic [11:0] REG_FRAME_LENGTH = 12'h61A;
	localparam logic [11:0] REG_FRAME_GAP = 12'h61B;
	localparam logic [11:0] REG_BYTE_TOTAL = 12'h61C;
	localparam logic [11:0] REG_FRAME_LOW = 12'h61D;
	localparam logic [11:0] REG_FRAME_HIGH = 12'h61E;
	localparam logic [11:0] REG_STATUS_FLAGS = 12'h620;
	localparam logic [11:0] REG_CHK_CTRL = 12'h630;
	localparam logic [11:0] REG_IRQ_STATUS = 12'h631;
	localparam logic [11:0] REG_IRQ_ENABLE = 12'h632;
	localparam logic [11:0] REG_IRQ_CLEAR = 12'h633;
	// --------------------------------------------------------------
	// Reset values and limits
	// --------------------------------------------------------------
	localparam logic [15:0] FRAME_LENGTH_RST = 16'h05DC;
	localparam logic [7:0] FRAME_GAP_RST = 8'h7D;
	localparam logic [15:0] BYTE_TOTAL_MAX = 16'hFFFF;
	localparam logic [31:0] FRAME_TOTAL_MAX = 32'h0FFFFFFF;
	// --------------------------------------------------------------
	// Field positions
	// --------------------------------------------------------------
	localparam int BIT_FREEZE = 0;
	localparam int BIT_FREEZE_CLEAR = 1;
	localparam int BIT_LOCK = 8;
	localparam int BIT_BYTE_OVF = 9;
	localparam int BIT_FRAME_OVF = 10;
	localparam int BIT_BUSY = 11;
	localparam int BIT_DONE = 12;
	localparam int BIT_CHK_ENABLE = 0;
	localparam int BIT_CNT_MODE = 1;
	localparam int BIT_SEND = 2;
	localparam int IRQ_BITS = 4;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_BYTE_WRAP = 1;
	localparam int IRQ_FRAME_WRAP = 2;
	localparam int IRQ_LOCK = 3;
	localparam logic [15:0] CHK_CTRL_RST = 16'h0001;
	// --------------------------------------------------------------
	// Generator states
	// --------------------------------------------------------------
	typedef enum logic [2:0] {
		GEN_IDLE = 3'b001,
		GEN_FRAME = 3'b010,
		GEN_GAP = 3'b100
	} ptg_gen_state_t;
endpackage : ptg_pkg
